// [rss_map.svh]
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define RSS_CLK_MHZ        50
`define RSS_STR0_US        1
`define RSS_STR1_US        4
`define RSS_STR2_US        16
`define RSS_STR3_US        64
`define RSS_STR0_CYC       (`RSS_STR0_US * `RSS_CLK_MHZ)
`define RSS_STR1_CYC       (`RSS_STR1_US * `RSS_CLK_MHZ)
`define RSS_STR2_CYC       (`RSS_STR2_US * `RSS_CLK_MHZ)
`define RSS_STR3_CYC       (`RSS_STR3_US * `RSS_CLK_MHZ)
`define RSS_BOD_FILT_NS    2000
`define RSS_BOD_FILT_CYC   ((`RSS_BOD_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_SMON_FILT_NS   2000
`define RSS_SMON_FILT_CYC  ((`RSS_SMON_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_CNT_W          12
`define RSS_FILT_W         8

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RSS_ADR_W          8
`define RSS_CTRL_OFS       8'h00
`define RSS_FLAGS_OFS      8'h04
`define RSS_STAT_OFS       8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSS_CTRL_EN_BIT    0
`define RSS_CTRL_IE_BIT    6
`define RSS_CTRL_IF_BIT    7
`define RSS_FLG_POR_BIT    0
`define RSS_FLG_EXT_BIT    1
`define RSS_FLG_BOR_BIT    2
`define RSS_FLG_WDT_BIT    3
`define RSS_FLG_JTG_BIT    4
`define RSS_FLG_W          5
`define RSS_STAT_REF_BIT   3
`define RSS_STAT_RST_BIT   4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSS_FLAGS_RST      5'h00
`define RSS_CNT_RST        12'h000

`endif

// [rss_persist.sv]
// Persistence filter: a level counts only once it has held for LIMIT+1 cycles
module rss_persist #(
  parameter int         W     = 8,
  parameter logic [7:0] LIMIT = 8'h01
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic lvl,
  output logic      hit
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (rst || !en || !lvl) begin
      cnt_r <= '0;
      hit   <= 1'b0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + W'(1);
    end else begin
      hit   <= 1'b1;
    end
  end

endmodule

// [rss_pkg.sv]
// Types shared by the reset and supply supervisor
package rss_pkg;

  // --------------------------------------------------------------------------
  // Stretch sequencer phases
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSS_HOLD  = 2'b00,
    RSS_COUNT = 2'b01,
    RSS_RUN   = 2'b10
  } rss_phase_t;

  // --------------------------------------------------------------------------
  // Clocked state of the supervisor, apart from the filters, synchroniser and port reset flop
  // --------------------------------------------------------------------------
  typedef struct packed {
    rss_phase_t  phase;
    logic [11:0] cnt;
    logic        sys_rst;
    logic        fetch;
    logic        wdt_prev;
    logic        wdt_pulse;
    logic        smon_en;
    logic        smon_ie;
    logic        smon_if;
    logic        smon_irq;
    logic        ref_en;
    logic [4:0]  flags;
    logic        ack;
    logic [7:0]  rdat;
  } rss_state_t;

endpackage

// [rss_src_model.sv]
// Model of the reset pin, supply detectors, watchdog and JTAG register
module rss_src_model (
  input  wire logic        mclk,
  input  wire logic [2:0]  sel,
  input  wire logic [11:0] len,
  input  wire logic        go,
  output logic             por_low,
  output logic             ext_rst_n,
  output logic             jtag_reset_bit,
  output logic             bod_low,
  output logic             smon_low,
  output logic             wdt_expire,
  output logic             busy
);
  logic [11:0] left_r = 12'h000;
  logic [2:0]  sel_r  = 3'h0;
  // The chosen source holds its level for exactly len cycles
  always @(posedge mclk) begin
    if (go) begin
      left_r <= len;
      sel_r  <= sel;
    end else if (left_r != 12'h000) begin
      left_r <= left_r - 12'h001;
    end
  end
  assign busy           = (left_r != 12'h000);
  assign por_low        = busy && sel_r == 3'h0;
  // Pin has a pull-up, so it idles high between pulses
  assign ext_rst_n      = !(busy && sel_r == 3'h1);
  assign jtag_reset_bit = busy && sel_r == 3'h2;
  assign bod_low        = busy && sel_r == 3'h3;
  assign smon_low       = busy && sel_r == 3'h4;
  assign wdt_expire     = busy && sel_r == 3'h5;
endmodule

// [rss_supervisor.sv]
// Reset and supply supervisor: reset merging, stretch, reference, monitor
`include "rss_map.svh"

module rss_supervisor
  import rss_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     por_low,
  input  wire logic                     ext_rst_n,
  input  wire logic                     jtag_reset_bit,
  input  wire logic                     bod_low,
  input  wire logic                     smon_low,
  input  wire logic                     wdt_expire,
  input  wire logic                     wdt_reset_en,
  input  wire logic                     global_irq_en,
  input  wire logic [1:0]               startup_delay_fuses,
  input  wire logic                     brownout_enable_fuse,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`RSS_ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          port_reset,
  output logic                          io_reg_reset,
  output logic                          fetch_reset_vector,
  output logic                          ref_enable,
  output logic                          supply_monitor_active,
  output logic                          supply_monitor_irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [7:0] pins_s;
  logic       por_s;
  logic       ext_s;
  logic       jtag_s;
  logic       bod_s;
  logic       smon_s;
  logic [1:0] dly_sel_s;
  logic       bod_fuse_s;

  rss_sync2 #(
    .W (8)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({brownout_enable_fuse, startup_delay_fuses, smon_low,
            bod_low, jtag_reset_bit, ~ext_rst_n, por_low}),
    .q    (pins_s)
  );

  assign por_s      = pins_s[0];
  assign ext_s      = pins_s[1];
  assign jtag_s     = pins_s[2];
  assign bod_s      = pins_s[3];
  assign smon_s     = pins_s[4];
  assign dly_sel_s  = pins_s[6:5];
  assign bod_fuse_s = pins_s[7];
  // The pin is inverted ahead of the synchroniser, so every source bit
  // reads high when active and the cleared flops mean no source at all;
  // mixing polarities here would hold the sequencer in reset for good

  // --------------------------------------------------------------------------
  // Persistence filters for brown-out and supply monitor
  // --------------------------------------------------------------------------
  logic bod_hit;
  logic smon_hit;
  rss_state_t st_r;
  rss_state_t st_nxt;

  // Filter is held clear while the fuse is off, so no reset can leak out
  rss_persist #(
    .W     (`RSS_FILT_W),
    .LIMIT (8'(`RSS_BOD_FILT_CYC))
  ) u_bod_filt (
    .mclk (mclk),
    .rst  (rst),
    .en   (bod_fuse_s),
    .lvl  (bod_s),
    .hit  (bod_hit)
  );

  // Monitor filter is held clear while the monitor is switched off
  rss_persist #(
    .W     (`RSS_FILT_W),
    .LIMIT (8'(`RSS_SMON_FILT_CYC))
  ) u_smon_filt (
    .mclk (mclk),
    .rst  (rst),
    .en   (st_r.smon_en),
    .lvl  (smon_s),
    .hit  (smon_hit)
  );

  // --------------------------------------------------------------------------
  // Asynchronous reset assertion
  // --------------------------------------------------------------------------
  // Pin sources act without any clock; release still follows the
  // clocked sequencer so the edge is clean for downstream logic.
  logic async_src;
  logic port_reset_r;

  assign async_src = por_low | ~ext_rst_n | jtag_reset_bit;

  // Raw pins on purpose: a synchroniser needs the clock that may be
  // missing; rst is sampled, so it only acts on a clock edge
  always_ff @(posedge mclk or posedge async_src) begin
    if (async_src) begin
      port_reset_r <= 1'b1;
    end else if (rst) begin
      port_reset_r <= 1'b1;
    end else begin
      port_reset_r <= st_r.sys_rst;
    end
  end

  assign port_reset = port_reset_r;

  // --------------------------------------------------------------------------
  // Source merge and stretch length
  // --------------------------------------------------------------------------
  logic                  src_any;
  logic [`RSS_CNT_W-1:0] limit;

  assign src_any = por_s | ext_s | st_r.wdt_pulse | bod_hit |
                   jtag_s;

  // The count runs from zero to limit-1, so the stretch lasts exactly
  // limit cycles once the last source has been seen clear
  always_comb begin
    case (dly_sel_s)
      2'h0:    limit = `RSS_CNT_W'(`RSS_STR0_CYC);
      2'h1:    limit = `RSS_CNT_W'(`RSS_STR1_CYC);
      2'h2:    limit = `RSS_CNT_W'(`RSS_STR2_CYC);
      default: limit = `RSS_CNT_W'(`RSS_STR3_CYC);
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic       bus_req;
  logic       wr_lo;
  logic [7:0] wbyte;

  // Taken only while ack is low, so ack lasts one cycle and a held request acks every other cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr_lo   = bus_req & wb_we_i & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    // Pulses and ack drop by default unless set again below
    st_nxt       = st_r;
    st_nxt.fetch = 1'b0;
    st_nxt.ack   = bus_req;

    // Watchdog expiry becomes a single cycle source
    st_nxt.wdt_prev  = wdt_expire;
    st_nxt.wdt_pulse = wdt_expire & ~st_r.wdt_prev & wdt_reset_en;

    // Reset stretch sequencer
    case (st_r.phase)
      RSS_HOLD: begin
        st_nxt.sys_rst = 1'b1;
        st_nxt.cnt     = `RSS_CNT_RST;
        if (!src_any) begin
          st_nxt.phase = RSS_COUNT;
        end
      end
      RSS_COUNT: begin
        // Restart instead of pausing: a new source earns the full stretch
        if (src_any) begin
          st_nxt.phase = RSS_HOLD;
          st_nxt.cnt   = `RSS_CNT_RST;
        end else if (st_r.cnt == limit - `RSS_CNT_W'(1)) begin
          st_nxt.phase   = RSS_RUN;
          st_nxt.sys_rst = 1'b0;
          st_nxt.fetch   = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + `RSS_CNT_W'(1);
        end
      end
      RSS_RUN: begin
        if (src_any) begin
          st_nxt.phase   = RSS_HOLD;
          st_nxt.sys_rst = 1'b1;
        end
      end
      default: begin
        st_nxt.phase   = RSS_HOLD;
        st_nxt.sys_rst = 1'b1;
      end
    endcase

    // Control register: writes, then hardware set wins over the clear
    if (wr_lo && wb_adr_i == `RSS_CTRL_OFS) begin
      st_nxt.smon_en = wbyte[`RSS_CTRL_EN_BIT];
      st_nxt.smon_ie = wbyte[`RSS_CTRL_IE_BIT];
      if (!wbyte[`RSS_CTRL_IF_BIT]) begin
        st_nxt.smon_if = 1'b0;
      end
    end
    if (smon_hit) begin
      st_nxt.smon_if = 1'b1;
    end
    if (st_r.sys_rst) begin
      st_nxt.smon_en = 1'b0;
      st_nxt.smon_ie = 1'b0;
      st_nxt.smon_if = 1'b0;
    end

    // Reset cause flags survive the internal reset by design
    if (wr_lo && wb_adr_i == `RSS_FLAGS_OFS) begin
      st_nxt.flags = st_r.flags & wbyte[`RSS_FLG_W-1:0];
    end
    // Power-on outranks the other causes and leaves only its own bit
    if (por_s) begin
      st_nxt.flags[`RSS_FLG_EXT_BIT] = 1'b0;
      st_nxt.flags[`RSS_FLG_BOR_BIT] = 1'b0;
      st_nxt.flags[`RSS_FLG_WDT_BIT] = 1'b0;
      st_nxt.flags[`RSS_FLG_JTG_BIT] = 1'b0;
      st_nxt.flags[`RSS_FLG_POR_BIT] = 1'b1;
    end else begin
      if (ext_s) begin
        st_nxt.flags[`RSS_FLG_EXT_BIT] = 1'b1;
      end
      if (bod_hit) begin
        st_nxt.flags[`RSS_FLG_BOR_BIT] = 1'b1;
      end
      if (st_r.wdt_pulse) begin
        st_nxt.flags[`RSS_FLG_WDT_BIT] = 1'b1;
      end
      if (jtag_s) begin
        st_nxt.flags[`RSS_FLG_JTG_BIT] = 1'b1;
      end
    end

    st_nxt.ref_en   = bod_fuse_s | st_r.smon_en;
    st_nxt.smon_irq = st_r.smon_if & st_r.smon_ie & global_irq_en;

    // Read data; unmapped addresses answer zero
    st_nxt.rdat = 8'h00;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `RSS_CTRL_OFS: begin
          st_nxt.rdat[`RSS_CTRL_EN_BIT] = st_r.smon_en;
          st_nxt.rdat[`RSS_CTRL_IE_BIT] = st_r.smon_ie;
          st_nxt.rdat[`RSS_CTRL_IF_BIT] = st_r.smon_if;
        end
        `RSS_FLAGS_OFS: begin
          st_nxt.rdat[`RSS_FLG_W-1:0] = st_r.flags;
        end
        `RSS_STAT_OFS: begin
          st_nxt.rdat[1:0]               = dly_sel_s;
          st_nxt.rdat[2]                 = bod_fuse_s;
          st_nxt.rdat[`RSS_STAT_REF_BIT] = st_r.ref_en;
          st_nxt.rdat[`RSS_STAT_RST_BIT] = st_r.sys_rst;
          st_nxt.rdat[6:5]               = st_r.phase;
        end
        default: begin
          st_nxt.rdat = 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Reset image: the sequencer holds and the internal reset is asserted
  localparam rss_state_t st_rst_val = '{
    phase:     RSS_HOLD,
    cnt:       `RSS_CNT_RST,
    sys_rst:   1'b1,
    fetch:     1'b0,
    wdt_prev:  1'b0,
    wdt_pulse: 1'b0,
    smon_en:   1'b0,
    smon_ie:   1'b0,
    smon_if:   1'b0,
    smon_irq:  1'b0,
    ref_en:    1'b0,
    flags:     `RSS_FLAGS_RST,
    ack:       1'b0,
    rdat:      8'h00
  };

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= st_rst_val;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Bits above the low byte stay zero: each register is one byte wide
  assign wb_dat_o              = {24'h000000, st_r.rdat};
  assign wb_ack_o              = st_r.ack;
  assign io_reg_reset          = st_r.sys_rst;
  assign fetch_reset_vector    = st_r.fetch;
  assign ref_enable            = st_r.ref_en;
  assign supply_monitor_active = st_r.smon_en;
  assign supply_monitor_irq    = st_r.smon_irq;

endmodule

// [rss_supervisor_sva.sv]
// Concurrent checks on the supervisor's ports
module rss_supervisor_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        por_low,
  input wire logic        ext_rst_n,
  input wire logic        jtag_reset_bit,
  input wire logic        brownout_enable_fuse,
  input wire logic        global_irq_en,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        port_reset,
  input wire logic        io_reg_reset,
  input wire logic        fetch_reset_vector,
  input wire logic        ref_enable,
  input wire logic        supply_monitor_active,
  input wire logic        supply_monitor_irq
);
  logic [11:0] qcnt_r;
  // Quiet time of the pin sources, saturating so it never wraps
  always_ff @(posedge mclk) begin
    if (rst || por_low || !ext_rst_n || jtag_reset_bit) begin
      qcnt_r <= 12'h000;
    end else if (qcnt_r != 12'hfff) begin
      qcnt_r <= qcnt_r + 12'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_port_async: assert property (
    (por_low || !ext_rst_n || jtag_reset_bit) |-> port_reset)
    else $error("port reset not set by active source");
  chk_stretch_min: assert property (
    $fell(io_reg_reset) |-> qcnt_r >= 12'h032)
    else $error("internal reset released too early");
  chk_port_follow: assert property (
    $fell(io_reg_reset) |=> $fell(port_reset))
    else $error("port reset did not follow internal reset");
  chk_fetch_once: assert property (
    fetch_reset_vector |-> $fell(io_reg_reset) ##1 !fetch_reset_vector)
    else $error("fetch pulse misplaced");
  chk_jtag_hold: assert property (
    jtag_reset_bit [*5] |-> io_reg_reset)
    else $error("jtag bit did not hold reset");
  chk_ref_off: assert property (
    (!brownout_enable_fuse && !supply_monitor_active) [*4] |-> !ref_enable)
    else $error("reference on with nothing using it");
  chk_ref_on: assert property (
    (brownout_enable_fuse || supply_monitor_active) [*4] |-> ref_enable)
    else $error("reference off while needed");
  chk_irq_gate: assert property (
    supply_monitor_irq |-> $past(global_irq_en))
    else $error("monitor irq without global enable");
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than a cycle");
  chk_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
endmodule

bind rss_supervisor rss_supervisor_sva u_sva (.*);

// [rss_supervisor_test.sv]
// Self-checking bench for the reset and supply supervisor
module rss_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic go = 1'b0, wen = 1'b0, gie = 1'b0, bfuse = 1'b0;
  logic [1:0]  fuse = 2'h0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, lf = 32'h0001288e;
  logic [2:0]  src  = 3'h0;
  logic [11:0] len  = 12'h000;
  logic        por, ext_n, jtag, bod, smon, wdt, busy, ack;
  logic        prst, iorst, fetch, refe, mact, irq;
  int n_fail = 0, tests_run = 0, cyc_n = 0, since = 0;
  logic [31:0] exp_rd[$];
  int          exp_rel[$];
  int c_src[10]  = '{0, 1, 2, 1, 3, 3, 3, 5, 5, 1};
  int c_len[10]  = '{0, 0, 0, 0, 300, 40, 300, 1, 1, 0};
  int c_fuse[10] = '{0, 1, 2, 3, 0, 0, 0, 0, 0, 1};
  int c_bf[10]   = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
  int c_wen[10]  = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0};
  int c_rel[10]  = '{1, 1, 1, 1, 1, 0, 0, 1, 0, 1};
  int c_flag[10] = '{1, 2, 16, 2, 4, 0, 0, 8, 0, 2};
  always #10 mclk = ~mclk;
  rss_src_model u_rss_src_model (.mclk(mclk), .sel(src), .len(len),
    .go(go), .por_low(por), .ext_rst_n(ext_n), .jtag_reset_bit(jtag),
    .bod_low(bod), .smon_low(smon), .wdt_expire(wdt), .busy(busy));
  rss_supervisor u_rss_supervisor (.mclk(mclk), .rst(rst), .por_low(por),
    .ext_rst_n(ext_n), .jtag_reset_bit(jtag), .bod_low(bod),
    .smon_low(smon), .wdt_expire(wdt), .wdt_reset_en(wen),
    .global_irq_en(gie), .startup_delay_fuses(fuse),
    .brownout_enable_fuse(bfuse), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_reset(prst),
    .io_reg_reset(iorst), .fetch_reset_vector(fetch), .ref_enable(refe),
    .supply_monitor_active(mact), .supply_monitor_irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sync and pulse latency allow a few cycles beyond the nominal stretch
  task automatic cmp_rel(input int got, input int n);
    tests_run++;
    if (got < n || got > n + 10) begin
      n_fail++;
      $display("Error t=%0t count=%h exp=%h", $time, got, n);
    end
  endtask
  task automatic conclude();
    if (exp_rel.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input logic [2:0] s, input logic [11:0] n);
    @(posedge mclk);
    src <= s;
    len <= n;
    go  <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (int'(n) + 2) @(posedge mclk);
  endtask
  // Watches the outputs and takes the oldest note for each result
  always @(posedge mclk) begin
    cyc_n++;
    since = (rst || por || !ext_n || jtag || bod || wdt) ? 0 : since + 1;
    if (ack === 1'b1 && !we)
      cmp_val(rdat, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    if (fetch === 1'b1)
      cmp_rel(since, exp_rel.size() ? exp_rel.pop_front() : -100);
    if (cyc_n > 60000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    exp_rel.push_back(50);
    repeat (100) @(posedge mclk);
    gie <= 1'b1;
    wb(1'b1, 8'h00, 8'h41);
    pulse(3'h4, 12'h028);
    rd(8'h00, 8'h41);
    cmp_val({31'h0, irq}, 32'h0);
    pulse(3'h4, 12'h096);
    rd(8'h00, 8'hc1);
    cmp_val({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h00, 8'hc1);
    rd(8'h00, 8'hc1);
    wb(1'b1, 8'h00, 8'h41);
    rd(8'h00, 8'h41);
    cmp_val({31'h0, irq}, 32'h0);
    rd(8'h08, 8'h48);
    wb(1'b1, 8'h08, lf[7:0]);
    rd(8'h08, 8'h48);
    wb(1'b1, 8'h0c, lf[15:8]);
    rd(8'h0c, 8'h00);
    for (int i = 0; i < 10; i++) begin
      fuse  <= 2'(c_fuse[i]);
      bfuse <= c_bf[i][0];
      wen   <= c_wen[i][0];
      wb(1'b1, 8'h04, 8'h00);
      lf = lfsr(lf);
      if (c_rel[i] != 0) exp_rel.push_back(50 << (2 * c_fuse[i]));
      if (i == 9) pulse(3'h1, 12'h014);
      if (i == 9) repeat (20) @(posedge mclk);
      pulse(3'(c_src[i]), c_len[i] != 0 ? 12'(c_len[i]) : 12'(lf[5:0]) + 12'd8);
      repeat (3300) @(posedge mclk);
      rd(8'h04, 8'(c_flag[i]));
    end
    conclude();
  end
endmodule

// [rss_sync2.sv]
// Two flip-flop synchroniser for a vector of unrelated levels
module rss_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
